// ==== inc/pcld_pkg.sv ====
// Purpose: Shared constants for the progress code LED decoder
// Assumes: One system clock, synchronous active-high reset
// Notes:   Code byte is split into a red (upper) and green (lower) nibble

// ****************************************
// Package
// ****************************************
package pcld_pkg;
  localparam int          PCLD_CODE_W     = 8;
  localparam int          PCLD_LED_N      = 4;
  localparam int          PCLD_RED_LSB    = 4;
  localparam int          PCLD_GREEN_LSB  = 0;
  localparam logic [7:0]  PCLD_CODE_RST   = 8'h00;
  localparam logic [3:0]  PCLD_LED_OFF    = 4'h0;
endpackage

// ==== verilog/pcld_code_hold.sv ====
// Purpose: Holds the last progress byte written by the host
// Assumes: Write strobe and data come from logic on mclk_in
// Notes:   Held value comes straight out of a register

`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Code holding register
// ****************************************
module pcld_code_hold
  import pcld_pkg::*;
#(
  parameter int W = PCLD_CODE_W
) (
  input  wire logic         mclk_in,
  input  wire logic         srst_in,
  input  wire logic         wr_in,
  input  wire logic [W-1:0] data_in,
  output logic      [W-1:0] code_out
);

  logic [W-1:0] code_reg;
  logic [W-1:0] code_next;

  // Next value: new byte on strobe, else keep last one
  always_comb begin
    code_next = code_reg;
    if (wr_in) begin
      code_next = data_in; // [RQ6] [RQ7]
    end
  end

  // Register, cleared on reset
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      code_reg <= W'(PCLD_CODE_RST); // [RQ7]
    end else begin
      code_reg <= code_next;
    end
  end

  assign code_out = code_reg;

endmodule

`default_nettype wire

// ==== verilog/pcld_decoder.sv ====
// Purpose: Shows an 8-bit boot progress code on four two-colour LEDs
// Assumes: Host writes one byte per stage with a one-cycle strobe on mclk_in
// Notes:   Index 3 of each LED bus is the weight 8h position, index 0 weight 1h
//          Amber is shown as red and green lit together, off as both dark
//          LEDs trail the held code by one register stage
//          Every output comes straight from a register
//
// Notes on behaviour
// RQ1: Each LED position lights red when its upper-nibble bit is one.
// RQ2: Each LED position lights green when its lower-nibble bit is one.
// RQ3: With both bits one, red and green light together to show amber.
// RQ4: With both bits zero, the position stays dark.
// RQ5: Positions are ordered by weight, 8h most significant down to 1h least.
// RQ6: The host writes a byte per stage and the last byte written stays shown.
// RQ7: The byte comes in by a single write strobe and resets to zero, all dark.

`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Top module
// ****************************************
module pcld_decoder
  import pcld_pkg::*;
#(
  parameter int N = PCLD_LED_N
) (
  input  wire logic                   mclk_in,
  input  wire logic                   srst_in,
  input  wire logic                   code_wr_in,
  input  wire logic [PCLD_CODE_W-1:0] code_in,
  output logic      [N-1:0]           led_red_out,
  output logic      [N-1:0]           led_green_out,
  output logic      [PCLD_CODE_W-1:0] code_out
);

  // Held code and LED drive state
  logic [PCLD_CODE_W-1:0] held;
  logic [N-1:0]           red_reg;
  logic [N-1:0]           red_next;
  logic [N-1:0]           green_reg;
  logic [N-1:0]           green_next;

  // Holding register for the latest code
  pcld_code_hold #(
    .W        (PCLD_CODE_W)
  ) u_hold (
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .wr_in    (code_wr_in),
    .data_in  (code_in),
    .code_out (held)
  );

  // Per-position colour decode, same bit weight in both nibbles
  generate
    for (genvar i = 0; i < N; i++) begin : g_pos
      always_comb begin
        red_next[i]   = held[PCLD_RED_LSB + i];   // [RQ1] [RQ3] [RQ4] [RQ5]
        green_next[i] = held[PCLD_GREEN_LSB + i]; // [RQ2] [RQ3] [RQ4] [RQ5]
      end
    end
  endgenerate

  // LED drive registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      red_reg   <= N'(PCLD_LED_OFF); // [RQ7]
      green_reg <= N'(PCLD_LED_OFF); // [RQ7]
    end else begin
      red_reg   <= red_next;
      green_reg <= green_next;
    end
  end

  // Outputs straight from registers
  assign led_red_out   = red_reg;
  assign led_green_out = green_reg;
  assign code_out      = held;

  // ****************************************
  // Assertions
  // ****************************************
  red_follow_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ1]
    code_wr_in ##2 1 |-> led_red_out == $past(code_in[7:4], 2))
    else $error("red LEDs do not follow upper nibble");

  green_follow_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ2]
    code_wr_in ##2 1 |-> led_green_out == $past(code_in[3:0], 2))
    else $error("green LEDs do not follow lower nibble");

  amber_pos_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ3]
    (code_wr_in && code_in[7] && code_in[3]) |-> ##2 (led_red_out[3] && led_green_out[3]))
    else $error("top position not amber");

  dark_pos_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ4]
    (code_wr_in && !code_in[4] && !code_in[0]) |-> ##2 (!led_red_out[0] && !led_green_out[0]))
    else $error("bottom position not dark");

  weight_order_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ5]
    (code_wr_in && code_in == 8'h81) |-> ##2 (led_red_out == 4'h8 && led_green_out == 4'h1))
    else $error("LED weight order wrong");

  code_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ6]
    !code_wr_in |=> $stable(code_out))
    else $error("held code changed without write");

  reset_dark_a: assert property (@(posedge mclk_in) // [RQ7]
    srst_in |=> (code_out == 8'h00 && led_red_out == 4'h0 && led_green_out == 4'h0))
    else $error("not dark after reset");

  leds_match_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ6]
    !code_wr_in [*2] |-> {led_red_out, led_green_out} == code_out)
    else $error("LEDs disagree with held code");

  // ****************************************
  // Hold checks
  // ****************************************
  // Held code takes the written byte one edge later
  code_load_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ6]
    code_wr_in |=> code_out == $past(code_in))
    else $error("held code missed a write");

  // Whole byte reaches the LEDs two edges after the write
  byte_show_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ5]
    code_wr_in |-> ##2 ({led_red_out, led_green_out} == $past(code_in, 2)))
    else $error("LED pair does not show written byte");

  // LEDs stay put while no write comes in
  led_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ6]
    !code_wr_in [*2] |=> ($stable(led_red_out) && $stable(led_green_out)))
    else $error("LEDs changed without write");

  // Amber positions match the held code once settled
  amber_match_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ3]
    !code_wr_in [*2] |->
      ((led_red_out & led_green_out) == (code_out[PCLD_RED_LSB +: N] & code_out[PCLD_GREEN_LSB +: N])))
    else $error("amber positions disagree with held code");

  // Dark positions match the held code once settled
  dark_match_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ4]
    !code_wr_in [*2] |->
      ((led_red_out | led_green_out) == (code_out[PCLD_RED_LSB +: N] | code_out[PCLD_GREEN_LSB +: N])))
    else $error("dark positions disagree with held code");

  // ****************************************
  // Reset checks
  // ****************************************
  // Held code cleared by reset
  code_reset_a: assert property (@(posedge mclk_in) // [RQ7]
    srst_in |=> code_out == PCLD_CODE_RST)
    else $error("held code not cleared by reset");

  // Red elements dark after reset
  red_reset_a: assert property (@(posedge mclk_in) // [RQ7]
    srst_in |=> led_red_out == N'(PCLD_LED_OFF))
    else $error("red elements lit after reset");

  // Green elements dark after reset
  green_reset_a: assert property (@(posedge mclk_in) // [RQ7]
    srst_in |=> led_green_out == N'(PCLD_LED_OFF))
    else $error("green elements lit after reset");

  // Write during reset is dropped
  reset_write_a: assert property (@(posedge mclk_in) // [RQ7]
    (srst_in && code_wr_in) |=> code_out == PCLD_CODE_RST)
    else $error("write taken during reset");

  // Long reset keeps every position dark
  reset_hold_a: assert property (@(posedge mclk_in) // [RQ7]
    srst_in [*2] |-> (led_red_out == N'(PCLD_LED_OFF) && led_green_out == N'(PCLD_LED_OFF)))
    else $error("positions lit during reset");

  // ****************************************
  // Per-position checks
  // ****************************************
  // Each position checked by itself, weight 1h at index 0 up to 8h at index N-1
  generate
    for (genvar p = 0; p < N; p++) begin : g_chk
      // Red element follows its upper-nibble bit
      pos_red_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ1]
        code_wr_in |-> ##2 (led_red_out[p] == $past(code_in[PCLD_RED_LSB + p], 2)))
        else $error("red element wrong at one position");

      // Green element follows its lower-nibble bit
      pos_green_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ2]
        code_wr_in |-> ##2 (led_green_out[p] == $past(code_in[PCLD_GREEN_LSB + p], 2)))
        else $error("green element wrong at one position");

      // Both bits one give amber
      pos_amber_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ3]
        (code_wr_in && code_in[PCLD_RED_LSB + p] && code_in[PCLD_GREEN_LSB + p]) |-> ##2 (led_red_out[p] && led_green_out[p]))
        else $error("position not amber");

      // Both bits zero leave the position dark
      pos_dark_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ4]
        (code_wr_in && !code_in[PCLD_RED_LSB + p] && !code_in[PCLD_GREEN_LSB + p]) |-> ##2 (!led_red_out[p] && !led_green_out[p]))
        else $error("position not dark");

      // Upper bit alone gives red only
      pos_red_only_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ1]
        (code_wr_in && code_in[PCLD_RED_LSB + p] && !code_in[PCLD_GREEN_LSB + p]) |-> ##2 (led_red_out[p] && !led_green_out[p]))
        else $error("position not red only");

      // Lower bit alone gives green only
      pos_green_only_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ2]
        (code_wr_in && !code_in[PCLD_RED_LSB + p] && code_in[PCLD_GREEN_LSB + p]) |-> ##2 (!led_red_out[p] && led_green_out[p]))
        else $error("position not green only");

      // Position stays put while no write comes in
      pos_stable_a: assert property (@(posedge mclk_in) disable iff (srst_in) // [RQ6]
        !code_wr_in [*2] |=> ($stable(led_red_out[p]) && $stable(led_green_out[p])))
        else $error("position changed without write");
    end
  endgenerate

endmodule

`default_nettype wire

// ==== sim/pcld_host_model.sv ====
// Purpose: Host firmware model writing progress bytes
// Assumes: Bench calls the tasks after reset release
// Notes:   Data shows the inverse byte between writes
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host model
// ****************************************
module pcld_host_model (
  input  wire logic       mclk_in,
  output logic            code_wr_out,
  output logic      [7:0] code_data_out
);
  // Idle at time zero
  initial begin
    code_wr_out   = 1'b0;
    code_data_out = 8'h00;
  end
  // One strobed byte per stage, data not held after it
  task automatic write_code(input logic [7:0] b);
    @(posedge mclk_in);
    code_wr_out   <= 1'b1;
    code_data_out <= b;
    @(posedge mclk_in);
    code_wr_out   <= 1'b0;
    code_data_out <= ~b;
  endtask
  // Two stages started on consecutive cycles
  task automatic write_pair(input logic [7:0] a, input logic [7:0] b);
    @(posedge mclk_in);
    code_wr_out   <= 1'b1;
    code_data_out <= a;
    @(posedge mclk_in);
    code_data_out <= b;
    @(posedge mclk_in);
    code_wr_out   <= 1'b0;
    code_data_out <= ~b;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the progress code LED decoder
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes:   Outputs checked three edges after each write
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench top
// ****************************************
module tb;
  import pcld_pkg::*;
  logic       mclk_in, srst_in, wr;
  logic [7:0] data, code;
  logic [3:0] red, green;
  int         fails = 0;
  int         samples_checked = 0;
  // Clock source
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  pcld_host_model host (.mclk_in(mclk_in), .code_wr_out(wr), .code_data_out(data));
  pcld_decoder dut (.mclk_in(mclk_in), .srst_in(srst_in), .code_wr_in(wr), .code_in(data),
    .led_red_out(red), .led_green_out(green), .code_out(code));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Let LEDs settle, then compare; red 3..0 is code bit 7..4
  task automatic expect_code(input logic [7:0] c);
    repeat (3) @(posedge mclk_in);
    #1;
    check({red, green}, c);
    check(code, c);
  endtask
  // Reset on the edge after a write clears the held code before the LEDs show it, and ignores a write
  task automatic t_reset;
    host.write_code(8'h5a);
    srst_in <= 1'b1;
    host.write_code(8'hff);
    @(posedge mclk_in);
    srst_in <= 1'b0;
    expect_code(8'h00);
    host.write_code(8'h3c);
    expect_code(8'h3c);
  endtask
  // Codes covering off, red, green and amber at every weight
  task automatic t_walk;
    logic [7:0] tbl [7] = '{8'hac, 8'h0f, 8'hf0, 8'h5a, 8'hff, 8'h81, 8'h00};
    foreach (tbl[i]) begin
      host.write_code(tbl[i]);
      expect_code(tbl[i]);
    end
  endtask
  // Back-to-back writes, last one stays after a long idle
  task automatic t_last_wins;
    host.write_pair(8'h13, 8'h28);
    expect_code(8'h28);
    repeat (20) @(posedge mclk_in);
    expect_code(8'h28);
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    srst_in = 1'b1;
    repeat (8) @(posedge mclk_in);
    srst_in <= 1'b0;
    #1;
    check(code, PCLD_CODE_RST);
    check({red, green}, 8'h00);
    t_walk;
    t_last_wins;
    t_reset;
    results;
  end
  // Watchdog
  initial begin
    #20000;
    fails++;
    results;
  end
endmodule
`default_nettype wire
